// ---- logic/asw_pkg.sv ----
package asw_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    // clock, write, read, float and recovery figures for the slowest grade, in ns
    localparam int CLK_NS = 40;
    localparam int T_WC_NS = 150;
    localparam int T_WP_NS = 100;
    localparam int T_RC_NS = 150;
    localparam int T_HZ_NS = 50;
    localparam int T_RECOVER_NS = 5000000;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HZ_CYC = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 18;
    localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;

    typedef enum logic [2:0] {
        ASW_IDLE,
        ASW_WSETUP,
        ASW_WPULSE,
        ASW_RACCESS,
        ASW_TURN,
        ASW_RETAIN,
        ASW_WAKE
    } asw_state_t;
endpackage : asw_pkg

// ---- logic/asw_sync.sv ----
`timescale 1ns/1ns
module asw_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;
endmodule : asw_sync

// ---- logic/asw_sram_host.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - memory writes only while primary select low, strobe low, secondary high
// RULE2 - select arriving at or after strobe fall keeps memory pins undriven
// RULE3 - write strobe low forces memory data pins to high impedance
// RULE4 - host holds output gate high whenever memory pins must stay undriven
// RULE5 - during address change a select or the strobe stays inactive
// RULE6 - host drives data only after the memory has released the bus
// RULE7 - retention by primary select: secondary select held at a full level
// RULE8 - retention by secondary select low: other inputs may float
// RULE9 - write strobe stays high for the whole read cycle
// RULE10 - deselected memory neither writes nor drives, and keeps contents
module asw_sram_host #(
    parameter int RECOVER_CYCLES = asw_pkg::RECOVER_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [asw_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [asw_pkg::DATA_W-1:0] reqWdata,
    output logic rdValid,
    output logic [asw_pkg::DATA_W-1:0] rdData,
    input wire logic retainReq,
    output logic retaining,
    output logic [asw_pkg::ADDR_W-1:0] memAddr,
    output logic primary_select_n,
    output logic secondary_select,
    output logic memWe_n,
    output logic memOe_n,
    output logic [asw_pkg::DATA_W-1:0] memDqOut,
    output logic memDqOe_n,
    input wire logic [asw_pkg::DATA_W-1:0] memDqIn
);
    import asw_pkg::*;

    // refuse a recovery count that the counter cannot hold
    if (RECOVER_CYCLES < 1 || RECOVER_CYCLES >= (1 << CNT_W))
    begin : g_bad_recover
        $error("asw_sram_host: RECOVER_CYCLES out of range");
    end

    asw_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [DATA_W-1:0] rdData_r, rdData_nxt;
    logic rdValid_r, rdValid_nxt;
    logic pcs_r, pcs_nxt;
    logic scs_r, scs_nxt;
    logic we_r, we_nxt;
    logic oe_r, oe_nxt;
    logic dqOe_r, dqOe_nxt;
    logic [DATA_W-1:0] dqSync;

    asw_sync #(.WIDTH(DATA_W)) u_asw_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(memDqIn),
        .dout(dqSync)
    );

    localparam logic [CNT_W-1:0] WP_N = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] WC_REST = CNT_W'(WC_CYC - WP_CYC);
    // extra cycles cover the data synchroniser
    localparam int SYNC_STAGES = 2;
    localparam logic [CNT_W-1:0] RC_N = CNT_W'(RC_CYC + SYNC_STAGES);
    localparam logic [CNT_W-1:0] HZ_N = CNT_W'(HZ_CYC);

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != CNT_ZERO) ? cnt_r - CNT_ONE : CNT_ZERO;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdData_nxt = rdData_r;
        rdValid_nxt = 1'b0;
        pcs_nxt = pcs_r;
        scs_nxt = scs_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        dqOe_nxt = dqOe_r;
        unique case (state_r)
            ASW_IDLE:
            begin
                pcs_nxt = 1'b1;
                we_nxt = 1'b1;
                oe_nxt = 1'b1;
                dqOe_nxt = 1'b1;
                scs_nxt = 1'b1;
                if (retainReq)
                begin
                    // secondary low is the retention that lets the rest float
                    scs_nxt = 1'b0; // see RULE8
                    state_nxt = ASW_RETAIN;
                end
                else if (reqValid && reqWrite)
                begin
                    // write address moves while all strobes are idle; a read address loads on the edge that drops select and output gate
                    addr_nxt = reqAddr; // see RULE5
                    wdata_nxt = reqWdata;
                    state_nxt = ASW_WSETUP;
                end
                else if (reqValid)
                begin
                    addr_nxt = reqAddr; // see RULE5
                    state_nxt = ASW_RACCESS;
                    pcs_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    cnt_nxt = RC_N;
                end
            end
            ASW_WSETUP:
            begin
                // select and strobe fall together, memory never drives
                pcs_nxt = 1'b0; // see RULE2
                we_nxt = 1'b0; // see RULE1
                oe_nxt = 1'b1; // see RULE4
                dqOe_nxt = 1'b0; // see RULE6
                cnt_nxt = WP_N;
                state_nxt = ASW_WPULSE;
            end
            ASW_WPULSE:
            begin
                if (cnt_r == CNT_ONE)
                begin
                    we_nxt = 1'b1;
                    pcs_nxt = 1'b1;
                    cnt_nxt = WC_REST;
                    state_nxt = ASW_TURN;
                end
            end
            ASW_RACCESS:
            begin
                we_nxt = 1'b1; // see RULE9
                if (cnt_r == CNT_ONE)
                begin
                    rdData_nxt = dqSync;
                    rdValid_nxt = 1'b1;
                    pcs_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    cnt_nxt = HZ_N;
                    state_nxt = ASW_TURN;
                end
            end
            ASW_TURN:
            begin
                // release and output float time before the next cycle
                dqOe_nxt = 1'b1;
                if (cnt_r <= CNT_ONE)
                    state_nxt = ASW_IDLE;
            end
            ASW_RETAIN:
            begin
                // primary held inactive too, secondary at a full low level
                scs_nxt = 1'b0; // see RULE7
                pcs_nxt = 1'b1;
                if (!retainReq)
                begin
                    cnt_nxt = CNT_W'(RECOVER_CYCLES);
                    state_nxt = ASW_WAKE;
                end
            end
            ASW_WAKE:
            begin
                scs_nxt = 1'b0; // see RULE10
                if (cnt_r <= CNT_ONE)
                    state_nxt = ASW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ASW_IDLE;
            cnt_r <= CNT_ZERO;
            addr_r <= '0;
            wdata_r <= '0;
            rdData_r <= '0;
            rdValid_r <= 1'b0;
            pcs_r <= 1'b1;
            scs_r <= 1'b1;
            we_r <= 1'b1;
            oe_r <= 1'b1;
            dqOe_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
            pcs_r <= pcs_nxt;
            scs_r <= scs_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            dqOe_r <= dqOe_nxt;
        end
    end

    assign reqReady = (state_r == ASW_IDLE) && !retainReq;
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
    assign retaining = (state_r == ASW_RETAIN) || (state_r == ASW_WAKE);
    assign memAddr = addr_r;
    assign primary_select_n = pcs_r;
    assign secondary_select = scs_r;
    assign memWe_n = we_r;
    assign memOe_n = oe_r;
    assign memDqOut = wdata_r;
    assign memDqOe_n = dqOe_r;

    a_addr_stable_active: assert property (@(posedge clk) disable iff (!rst_n)
        (!pcs_r && scs_r && !we_r) |=> $stable(addr_r)) // see RULE5
        else $error("address moved during an active write");
    a_drive_gate_high: assert property (@(posedge clk) disable iff (!rst_n)
        !dqOe_r |-> oe_r) // see RULE6
        else $error("host drives data while output gate enabled");
    a_read_strobe_high: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ASW_RACCESS) |-> we_r) // see RULE9
        else $error("write strobe low during read");
    a_write_pulse_len: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(we_r) |-> !we_r [*3] ##1 we_r) // see RULE1
        else $error("write pulse length wrong");
    a_select_with_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pcs_r) && (state_r == ASW_WPULSE) |-> $fell(we_r)) // see RULE2
        else $error("select fell before write strobe");
    a_retain_held: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ASW_RETAIN) |-> !scs_r && pcs_r && we_r) // see RULE7
        else $error("retention levels wrong");
    a_retain_float_ok: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(retaining) |-> $past(state_r) == ASW_IDLE && dqOe_r) // see RULE8
        else $error("entered retention with bus driven");
    a_wake_deselect: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ASW_WAKE) |-> !scs_r && we_r && dqOe_r) // see RULE10
        else $error("memory selected during recovery");
    a_gate_off_write: assert property (@(posedge clk) disable iff (!rst_n)
        !we_r |-> oe_r) // see RULE4
        else $error("output gate low during write");

    c_write: cover property (@(posedge clk) disable iff (!rst_n) $rose(we_r) && state_r == ASW_TURN);
    c_read: cover property (@(posedge clk) disable iff (!rst_n) rdValid_r);
    c_retain: cover property (@(posedge clk) disable iff (!rst_n) state_r == ASW_WAKE ##1 state_r == ASW_IDLE);
endmodule : asw_sram_host

// ---- sim/asw_sram_model.sv ----
`timescale 1ns/1ns
module asw_sram_model
    import asw_pkg::*;
(
    clk,
    addr,
    selN,
    sel,
    weN,
    oeN,
    hostDq,
    hostOeN,
    dq,
    clash
);
    input wire logic clk;
    input wire logic [ADDR_W-1:0] addr;
    input wire logic selN;
    input wire logic sel;
    input wire logic weN;
    input wire logic oeN;
    input wire logic [DATA_W-1:0] hostDq;
    input wire logic hostOeN;
    output logic [DATA_W-1:0] dq;
    output logic clash;
    // only the low address byte is kept, so upper bits alias
    logic [DATA_W-1:0] mem [0:255];
    logic flip = 1'b0;
    logic [DATA_W-1:0] idle;
    wire logic selected = !selN && sel;
    wire logic writing = selected && !weN;
    wire logic driving = selected && weN && !oeN;
    // floating bus toggles so a stale value never reads back as good
    always @(posedge clk) flip <= ~flip;
    assign idle = flip ? 8'h5A : 8'hA5;
    assign dq = driving ? mem[addr[7:0]] : (!hostOeN ? hostDq : idle);
    assign clash = driving && !hostOeN;
    always @(negedge writing) mem[addr[7:0]] <= dq;
endmodule : asw_sram_model

// ---- sim/async_sram_write_and_retention_tb.sv ----
`timescale 1ns/1ns
module async_sram_write_and_retention_tb;
    import asw_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic retainReq = 1'b0;
    logic [ADDR_W-1:0] reqAddr = 17'h00000;
    logic [DATA_W-1:0] reqWdata = 8'h00;
    logic reqReady, rdValid, retaining, pSelN, sSel, weN, oeN, dqOeN, clash, prevWr;
    logic [DATA_W-1:0] rdData, dqOut, dqIn;
    logic [ADDR_W-1:0] memAddr, prevAddr;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    wire logic wrNow = !pSelN && sSel && !weN;
    always #20 clk = ~clk;
    asw_sram_host #(.RECOVER_CYCLES(4)) u_asw_sram_host (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
        .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .rdValid(rdValid),
        .rdData(rdData), .retainReq(retainReq), .retaining(retaining), .memAddr(memAddr),
        .primary_select_n(pSelN), .secondary_select(sSel), .memWe_n(weN), .memOe_n(oeN),
        .memDqOut(dqOut), .memDqOe_n(dqOeN), .memDqIn(dqIn));
    asw_sram_model u_asw_sram_model (.clk(clk), .addr(memAddr), .selN(pSelN), .sel(sSel), .weN(weN),
        .oeN(oeN), .hostDq(dqOut), .hostOeN(dqOeN), .dq(dqIn), .clash(clash));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // request held until the edge that samples ready high
    task automatic send(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n = 0;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (reqReady !== 1'b1 && n < 40);
        reqValid <= 1'b0;
        // one edge with valid low so a following call never reassigns it in this step
        @(posedge clk);
    endtask : send
    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        int n = 0;
        send(1'b0, a, 8'h00);
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rdValid !== 1'b1 && n < 20);
        check(rdValid, 1'b1);
        check(rdData, e);
        @(posedge clk);
    endtask : read_chk
    task automatic t_write_read();
        send(1'b1, 17'h00003, 8'hA5);
        send(1'b1, 17'h1FF10, 8'h3C);
        read_chk(17'h1FF10, 8'h3C);
        read_chk(17'h00003, 8'hA5);
        send(1'b1, 17'h00003, 8'hFF);
        read_chk(17'h00003, 8'hFF);
        $display("write_read done");
    endtask : t_write_read
    task automatic t_retain();
        send(1'b1, 17'h00055, 8'h96);
        retainReq <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        check(retaining, 1'b1);
        check(reqReady, 1'b0);
        @(posedge clk);
        retainReq <= 1'b0;
        read_chk(17'h00055, 8'h96);
        $display("retain done");
    endtask : t_retain
    // pin-level watch on every cycle out of reset
    always @(negedge clk)
    begin
        if (rst_n)
        begin
            check(clash, 1'b0);
            if (!dqOeN) check(oeN, 1'b1);
            if (!oeN) check(weN, 1'b1);
            if (retaining) check({pSelN, sSel}, 2'b10);
            if (memAddr !== prevAddr) check(prevWr | wrNow, 1'b0);
        end
        prevAddr = memAddr;
        prevWr = wrNow;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_write_read();
        t_retain();
        conclude();
    end
endmodule : async_sram_write_and_retention_tb
